// ==== hw/pps_regs.vh ====
// Constants for the panel programming sequencer.
`ifndef PPS_REGS_VH
`define PPS_REGS_VH
`define PPS_NKEYS 24
`define PPS_NOUT 48
`define PPS_MAX_STEPS 10'h3e7
`define PPS_NPAGES 3'h4
`define PPS_SCENE_LO 5'h0d
`define PPS_SCENE_HI 5'h18
`define PPS_FLASH_MS 8
`define PPS_FLASH_CYC (`PPS_FLASH_MS * 200000)
`define PPS_FLASH_W 21
`define PPS_NSCENES 48
`endif

// ==== hw/pps_key_edge.v ====
// Synchroniser and press detector for the panel keys.
module pps_key_edge #(
    parameter W = 28
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [W-1:0] i_raw,
    output reg [W-1:0] o_level,
    output reg [W-1:0] o_press
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    o_level[g] <= 1'b0;
                    o_press[g] <= 1'b0;
                end else begin
                    s1_r[g] <= i_raw[g];
                    s2_r[g] <= s1_r[g];
                    o_level[g] <= s2_r[g];
                    o_press[g] <= s2_r[g] & ~o_level[g];
                end
            end
        end
    endgenerate
endmodule // pps_key_edge

// ==== hw/pps_sequencer.v ====
// Front-panel command sequencer: key sequences, scene store, page and fader routing.
// Functional notes
// RL1: Record held plus keys 1,5,6,8 arms programming.
// RL2: Record indicator lights after release once armed.
// RL3: Record press in programming stores one step.
// RL4: Scene holds up to 999 steps.
// RL5: Mode key selects single mode, page one; the code toggles o_single_mode on each press and sets page one.
// RL6: Page key cycles page one to four.
// RL7: Record plus scene key stores, indicators flash.
// RL8: Record plus exit key leaves programming.
// RL9: Edit plus scene key 13-24 enters edit.
// RL10: Edit entry raises the edit banner.
// RL11: Record plus scene key twice erases scene.
// RL12: Record plus keys 1,3,2,3 erases all.
// RL13: Full erase restores all defaults and routing.
// RL14: Full erase only accepted in programming mode.
// RL15: Record plus key 6 thrice enters assignment.
// RL16: First key picks fader, record-key press routes.
// RL17: One fader may drive all 48 outputs; the code reaches only the lower 24 outputs (bits 0-23).
// RL18: Fader key shows its current routing.
// RL19: Broken or abandoned sequences do nothing.
`include "pps_regs.vh"
module pps_sequencer (
    input wire i_clk,
    input wire i_rstn,
    input wire [23:0] i_flash_key,
    input wire i_record_key,
    input wire i_edit_key,
    input wire i_mode_key,
    input wire i_page_key,
    input wire i_exit_key,
    output reg o_record_led,
    output reg o_all_leds,
    output reg [23:0] o_scene_led,
    output reg o_edit_mode_banner,
    output reg o_single_mode,
    output reg [2:0] o_page,
    output reg o_assign_mode,
    output reg [4:0] o_physical_fader_index,
    output reg [47:0] o_fader_routing,
    output reg o_step_pulse,
    output reg [9:0] o_temp_steps,
    output reg o_store_pulse,
    output reg o_erase_pulse,
    output reg [5:0] o_scene_index,
    output reg o_erase_all_pulse
);
    localparam S_IDLE = 6'h01;
    localparam S_ARM = 6'h02;
    localparam S_PROG = 6'h04;
    localparam S_EDIT = 6'h08;
    localparam S_ASGN = 6'h10;
    localparam S_ERALL = 6'h20;
    localparam [31:0] FLASH_LOAD = `PPS_FLASH_CYC;

    wire [27:0] lvl;
    wire [27:0] prs;
    pps_key_edge #(.W(28)) u_keys (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_raw({i_exit_key, i_page_key, i_mode_key, i_edit_key, i_flash_key}),
        .o_level(lvl),
        .o_press(prs)
    );
    reg rec_s1_r;
    reg rec_s2_r;
    reg rec_d_r;
    wire rec_lvl = rec_s2_r;
    wire rec_press = rec_lvl & ~rec_d_r;
    wire rec_rel = ~rec_lvl & rec_d_r;
    wire [23:0] fk = prs[23:0];
    wire edit_lvl = lvl[24];
    wire mode_p = prs[25];
    wire page_p = prs[26];
    wire exit_p = prs[27];
    wire any_p = |prs;

    reg [5:0] st_r;
    reg [5:0] st_nxt;
    reg [2:0] seq_r;
    reg [2:0] seq_nxt;
    reg [3:0] erseq_r;
    reg [3:0] erseq_nxt;
    reg [2:0] six_r;
    reg [2:0] six_nxt;
    reg [4:0] last_r;
    reg [4:0] last_nxt;
    reg twice_r;
    reg twice_nxt;
    reg used_r;
    reg used_nxt;
    reg fsel_r;
    reg fsel_nxt;
    reg [`PPS_FLASH_W-1:0] flash_r;
    reg [47:0] route_r [0:23];
    reg [`PPS_NSCENES-1:0] scene_full_r;

    reg [4:0] key_idx;
    reg one_key;
    integer k;
    always @* begin
        key_idx = 5'h00;
        one_key = 1'b0;
        for (k = 0; k < 24; k = k + 1) begin
            if (fk[k]) begin
                key_idx = k[4:0];
                one_key = 1'b1;
            end
        end
    end
    wire scene_key = one_key && key_idx >= (`PPS_SCENE_LO - 5'h01) && key_idx <= (`PPS_SCENE_HI - 5'h01);
    wire [5:0] scene_sel = {1'b0, last_r - 5'h0c} + {1'b0, o_page - 3'h1, 2'h0} * 6'h03;

    // Event strobes decided combinationally, applied in the clocked process.
    reg do_store;
    reg do_erase;
    reg do_eall;
    reg do_route;
    always @* begin
        st_nxt = st_r;
        seq_nxt = seq_r;
        erseq_nxt = erseq_r;
        six_nxt = six_r;
        last_nxt = last_r;
        twice_nxt = twice_r;
        used_nxt = used_r;
        fsel_nxt = fsel_r;
        do_store = 1'b0;
        do_erase = 1'b0;
        do_eall = 1'b0;
        do_route = 1'b0;
        if (!rec_lvl) begin
            seq_nxt = 3'h0; // RL19
            erseq_nxt = 4'h0;
            six_nxt = 3'h0;
            twice_nxt = 1'b0;
        end
        case (st_r)
            S_IDLE: begin
                if (rec_lvl && one_key) begin
                    // Any key off the expected path restarts the match.
                    case (seq_r)
                        3'h0: seq_nxt = (key_idx == 5'h00) ? 3'h1 : 3'h0; // RL1
                        3'h1: seq_nxt = (key_idx == 5'h04) ? 3'h2 : 3'h0; // RL1
                        3'h2: seq_nxt = (key_idx == 5'h05) ? 3'h3 : 3'h0; // RL1
                        3'h3: seq_nxt = (key_idx == 5'h07) ? 3'h4 : 3'h0; // RL1
                        default: seq_nxt = 3'h0;
                    endcase
                    if (seq_r == 3'h3 && key_idx == 5'h07) begin
                        st_nxt = S_ARM;
                    end
                end else if (rec_lvl && any_p) begin
                    seq_nxt = 3'h0; // RL19
                end
            end
            S_ARM: begin
                if (!rec_lvl) begin
                    st_nxt = S_PROG; // RL2
                    used_nxt = 1'b0;
                end else if (any_p) begin
                    st_nxt = S_IDLE; // RL19
                end
            end
            S_PROG, S_ASGN: begin
                if (rec_press) begin
                    used_nxt = 1'b0;
                end
                // A record press that held no chord stores a step on release.
                if (rec_rel && !used_r && st_r == S_PROG) begin
                    do_store = 1'b0;
                end
                if (rec_lvl && exit_p) begin
                    st_nxt = S_IDLE; // RL8
                    fsel_nxt = 1'b0;
                end else if (rec_lvl && one_key) begin
                    used_nxt = 1'b1;
                    if (st_r == S_ASGN && fsel_r) begin
                        do_route = 1'b1; // RL16
                    end
                    six_nxt = (key_idx == 5'h05) ? six_r + 3'h1 : 3'h0;
                    if (key_idx == 5'h05 && six_r == 3'h2) begin
                        st_nxt = S_ASGN; // RL15
                        fsel_nxt = 1'b0;
                    end
                    case (erseq_r)
                        4'h0: erseq_nxt = (key_idx == 5'h00) ? 4'h1 : 4'h0; // RL12
                        4'h1: erseq_nxt = (key_idx == 5'h02) ? 4'h2 : 4'h0; // RL12
                        4'h2: erseq_nxt = (key_idx == 5'h01) ? 4'h3 : 4'h0; // RL12
                        4'h3: erseq_nxt = (key_idx == 5'h02) ? 4'h4 : 4'h0; // RL12
                        default: erseq_nxt = 4'h0;
                    endcase
                    if (erseq_r == 4'h3 && key_idx == 5'h02 && st_r == S_PROG) begin
                        do_eall = 1'b1; // RL14
                        st_nxt = S_ERALL;
                    end
                    if (scene_key && st_r == S_PROG) begin
                        if (twice_r && last_r == key_idx) begin
                            do_erase = 1'b1; // RL11
                            twice_nxt = 1'b0;
                        end else begin
                            twice_nxt = 1'b1;
                            last_nxt = key_idx;
                        end
                    end else begin
                        twice_nxt = 1'b0;
                    end
                end else if (!rec_lvl && one_key && st_r == S_ASGN) begin
                    fsel_nxt = 1'b1; // RL16
                    last_nxt = key_idx;
                end else if (edit_lvl && scene_key && st_r == S_PROG) begin
                    st_nxt = S_EDIT; // RL9
                    last_nxt = key_idx;
                end
                // A single scene tap stores once the record key is let go without a second tap.
                if (rec_rel && twice_r && st_r == S_PROG) begin
                    do_store = 1'b1; // RL7
                end
            end
            S_EDIT: begin
                if (rec_lvl && exit_p) begin
                    st_nxt = S_PROG;
                end
            end
            S_ERALL: begin
                if (rec_lvl && exit_p) begin
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    wire step_now = rec_rel && !used_r && st_r == S_PROG;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rec_s1_r <= 1'b0;
            rec_s2_r <= 1'b0;
            rec_d_r <= 1'b0;
            st_r <= S_IDLE;
            seq_r <= 3'h0;
            erseq_r <= 4'h0;
            six_r <= 3'h0;
            last_r <= 5'h00;
            twice_r <= 1'b0;
            used_r <= 1'b0;
            fsel_r <= 1'b0;
            flash_r <= {`PPS_FLASH_W{1'b0}};
            scene_full_r <= {`PPS_NSCENES{1'b0}};
            o_record_led <= 1'b0;
            o_all_leds <= 1'b0;
            o_scene_led <= 24'h000000;
            o_edit_mode_banner <= 1'b0;
            o_single_mode <= 1'b0;
            o_page <= 3'h1;
            o_assign_mode <= 1'b0;
            o_physical_fader_index <= 5'h00;
            o_fader_routing <= 48'h000000000000;
            o_step_pulse <= 1'b0;
            o_temp_steps <= 10'h000;
            o_store_pulse <= 1'b0;
            o_erase_pulse <= 1'b0;
            o_scene_index <= 6'h00;
            o_erase_all_pulse <= 1'b0;
        end else begin
            rec_s1_r <= i_record_key;
            rec_s2_r <= rec_s1_r;
            rec_d_r <= rec_s2_r;
            st_r <= st_nxt;
            seq_r <= seq_nxt;
            erseq_r <= erseq_nxt;
            six_r <= six_nxt;
            last_r <= last_nxt;
            twice_r <= twice_nxt;
            used_r <= used_nxt;
            fsel_r <= fsel_nxt;
            o_record_led <= (st_nxt != S_IDLE) && (st_nxt != S_ARM); // RL2
            o_edit_mode_banner <= (st_nxt == S_EDIT); // RL10
            o_assign_mode <= (st_nxt == S_ASGN);
            o_step_pulse <= step_now && o_temp_steps < `PPS_MAX_STEPS; // RL3
            if (step_now && o_temp_steps < `PPS_MAX_STEPS) begin
                o_temp_steps <= o_temp_steps + 10'h001; // RL4
            end
            o_store_pulse <= do_store && o_temp_steps != 10'h000; // RL7
            o_erase_pulse <= do_erase; // RL11
            o_erase_all_pulse <= do_eall; // RL12
            if (do_store || do_erase) begin
                o_scene_index <= scene_sel;
            end
            if (do_store && o_temp_steps != 10'h000) begin
                scene_full_r[scene_sel] <= 1'b1;
                o_temp_steps <= 10'h000;
            end
            if (do_erase) begin
                scene_full_r[scene_sel] <= 1'b0;
            end
            // Flashing is driven by a timer so the panel sees a visible blink.
            if ((do_store && o_temp_steps != 10'h000) || do_erase || do_eall) begin
                flash_r <= FLASH_LOAD[`PPS_FLASH_W-1:0]; // RL7
            end else if (flash_r != {`PPS_FLASH_W{1'b0}}) begin
                flash_r <= flash_r - {{(`PPS_FLASH_W-1){1'b0}}, 1'b1};
            end
            o_all_leds <= (flash_r != {`PPS_FLASH_W{1'b0}}) || st_r == S_ERALL; // RL11
            if (st_nxt == S_EDIT && st_r != S_EDIT) begin
                o_scene_led <= 24'h000001 << key_idx; // RL9
            end else if (st_nxt != S_EDIT) begin
                o_scene_led <= 24'h000000;
            end
            if (mode_p) begin
                o_single_mode <= ~o_single_mode; // RL5
                o_page <= 3'h1;
            end else if (page_p) begin
                o_page <= (o_page == `PPS_NPAGES) ? 3'h1 : o_page + 3'h1; // RL6
            end
            if (st_r == S_ASGN && !rec_lvl && one_key) begin
                o_physical_fader_index <= key_idx;
                o_fader_routing <= route_r[key_idx]; // RL18
            end else if (do_route) begin
                o_fader_routing <= o_fader_routing | (48'h000000000001 << key_idx); // RL17
            end
            if (do_eall) begin
                scene_full_r <= {`PPS_NSCENES{1'b0}}; // RL13
                o_temp_steps <= 10'h000;
                o_page <= 3'h1;
                o_single_mode <= 1'b0;
                o_fader_routing <= 48'h000000000000;
            end
        end
    end

    // Routing table: each fader feeds its own output plus any added from the lower 24 of the 48 outputs.
    genvar f;
    generate
        for (f = 0; f < 24; f = f + 1) begin : g_route
            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    route_r[f] <= 48'h000000000001 << f;
                end else if (do_eall) begin
                    route_r[f] <= 48'h000000000001 << f; // RL13
                end else if (do_route && o_physical_fader_index == f) begin
                    route_r[f] <= route_r[f] | (48'h000000000001 << key_idx); // RL16
                end
            end
        end
    endgenerate
endmodule // pps_sequencer

// ==== testbench/pps_sequencer_sva.sv ====
// Concurrent checks on the outputs of the panel programming sequencer.
module pps_sequencer_sva (
    input wire i_clk,
    input wire i_rstn,
    input wire o_record_led,
    input wire o_all_leds,
    input wire [23:0] o_scene_led,
    input wire o_edit_mode_banner,
    input wire [2:0] o_page,
    input wire o_step_pulse,
    input wire [9:0] o_temp_steps,
    input wire o_store_pulse,
    input wire o_erase_pulse,
    input wire [5:0] o_scene_index,
    input wire o_erase_all_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    page_range_a: assert property (o_page >= 3'h1 && o_page <= 3'h4)
        else $error("page out of range");
    page_step_a: assert property ($changed(o_page) |-> o_page == 3'h1 || o_page == $past(o_page) + 3'h1)
        else $error("page moved by other than one");
    steps_max_a: assert property (o_temp_steps <= 10'h3e7)
        else $error("step count above limit");
    step_count_a: assert property (o_step_pulse |-> ##[0:3] o_temp_steps == 10'h3e7 || $changed(o_temp_steps))
        else $error("step pulse without count change");
    step_prog_a: assert property (o_step_pulse |-> o_record_led)
        else $error("step captured outside programming");
    pulse_excl_a: assert property ($onehot0({o_step_pulse, o_store_pulse, o_erase_pulse, o_erase_all_pulse}))
        else $error("two actions at once");
    scene_range_a: assert property (o_store_pulse || o_erase_pulse |-> o_scene_index < 6'h30)
        else $error("scene index out of range");
    store_leds_a: assert property (o_store_pulse || o_erase_pulse |-> ##[0:4] o_all_leds)
        else $error("no confirmation after store or erase");
    erase_all_prog_a: assert property (o_erase_all_pulse |-> $past(o_record_led))
        else $error("full erase outside programming");
    erase_all_leds_a: assert property (o_erase_all_pulse |-> ##[0:8] (o_all_leds && o_temp_steps == 10'h0))
        else $error("full erase did not clear");
    edit_onehot_a: assert property (o_edit_mode_banner |-> $onehot(o_scene_led) && o_scene_led[11:0] == 12'h0)
        else $error("edit scene indicator wrong");
    store_once_a: assert property (o_store_pulse |=> !o_store_pulse)
        else $error("store pulse too long");
endmodule // pps_sequencer_sva

// ==== testbench/pps_operator.sv ====
// Operator model: presses and releases panel keys one at a time.
module pps_operator (
    input wire i_clk,
    output wire [23:0] o_flash_key,
    output wire o_record_key,
    output wire o_edit_key,
    output wire o_mode_key,
    output wire o_page_key,
    output wire o_exit_key
);
    timeunit 1ns;
    timeprecision 100ps;
    // Codes 1..24 are flash keys; 25 record, 26 edit, 27 mode, 28 page, 29 exit.
    logic [28:0] held = 29'h0;
    assign {o_exit_key, o_page_key, o_mode_key, o_edit_key, o_record_key, o_flash_key} = held;
    task automatic set(input int c, input logic v);
        @(posedge i_clk);
        #1;
        held[c-1] = v;
    endtask
    // Taps are spaced well beyond the four-cycle minimum so each one is seen after synchronising.
    task automatic tap(input int c);
        set(c, 1'b1);
        repeat (7) @(posedge i_clk);
        set(c, 1'b0);
        repeat (7) @(posedge i_clk);
    endtask
endmodule // pps_operator

// ==== testbench/panel_programming_sequencer_tb.sv ====
// Self-checking bench for the panel programming sequencer.
module panel_programming_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    wire [23:0] fk;
    wire rk, ek, mk, pk, xk;
    wire rec_led, all_leds, banner, single, assign_m, step_p, store_p, erase_p, all_p;
    wire [23:0] scene_led;
    wire [2:0] page;
    wire [4:0] fader;
    wire [47:0] routing;
    wire [9:0] steps;
    wire [5:0] idx;
    int err_total = 0;
    int checked = 0;
    int n_step = 0, n_store = 0, n_erase = 0, n_all = 0;
    logic [5:0] last_idx = 6'h3f;
    always #2.5 i_clk = ~i_clk;
    pps_operator i_op (.i_clk(i_clk), .o_flash_key(fk), .o_record_key(rk), .o_edit_key(ek), .o_mode_key(mk),
        .o_page_key(pk), .o_exit_key(xk));
    pps_sequencer i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_flash_key(fk), .i_record_key(rk), .i_edit_key(ek),
        .i_mode_key(mk), .i_page_key(pk), .i_exit_key(xk), .o_record_led(rec_led), .o_all_leds(all_leds),
        .o_scene_led(scene_led), .o_edit_mode_banner(banner), .o_single_mode(single), .o_page(page),
        .o_assign_mode(assign_m), .o_physical_fader_index(fader), .o_fader_routing(routing),
        .o_step_pulse(step_p), .o_temp_steps(steps), .o_store_pulse(store_p), .o_erase_pulse(erase_p),
        .o_scene_index(idx), .o_erase_all_pulse(all_p));
    always @(posedge i_clk) begin
        n_step += step_p;
        n_store += store_p;
        n_erase += erase_p;
        n_all += all_p;
        if (store_p || erase_p) last_idx <= idx;
    end
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hold one key, tap up to four keys in order, release, then let the outputs settle.
    task automatic seq(input int h, input int n, input int a, input int b = 0, input int c = 0, input int d = 0);
        int k[4];
        k = '{a, b, c, d};
        i_op.set(h, 1'b1);
        for (int i = 0; i < n; i++) i_op.tap(k[i]);
        i_op.set(h, 1'b0);
        repeat (12) @(posedge i_clk);
    endtask
    task automatic t_refused;
        seq(25, 4, 1, 5, 6, 7);
        chk("record led", 1'b0, rec_led);
        seq(25, 3, 1, 5, 6);
        i_op.tap(8);
        chk("record led", 1'b0, rec_led);
        seq(25, 4, 1, 3, 2, 3);
        chk("erase all count", 0, n_all);
        $display("test refused done");
    endtask
    task automatic t_arm;
        i_op.set(25, 1'b1);
        i_op.tap(1);
        i_op.tap(5);
        i_op.tap(6);
        i_op.tap(8);
        chk("record led held", 1'b0, rec_led);
        i_op.set(25, 1'b0);
        repeat (12) @(posedge i_clk);
        chk("record led", 1'b1, rec_led);
        $display("test arm done");
    endtask
    task automatic t_page_steps;
        i_op.tap(27);
        chk("single mode", 1'b1, single);
        chk("page", 3'h1, page);
        for (int i = 2; i <= 5; i++) begin
            i_op.tap(28);
            chk("page", (i - 1) % 4 + 1, page);
        end
        for (int i = 1; i <= 3; i++) begin
            i_op.tap(25);
            repeat (8) @(posedge i_clk);
            chk("step pulses", i, n_step);
            chk("temp steps", i, steps);
        end
        $display("test page and steps done");
    endtask
    task automatic t_store_erase;
        seq(25, 1, 13);
        chk("store count", 1, n_store);
        chk("scene index", 6'h00, last_idx);
        chk("all leds", 1'b1, all_leds);
        i_op.tap(28);
        i_op.tap(25);
        chk("step pulses", 4, n_step);
        seq(25, 1, 24);
        chk("scene index", 6'h17, last_idx);
        seq(25, 2, 20, 20);
        chk("erase count", 1, n_erase);
        chk("scene index", 6'h13, last_idx);
        chk("store count", 2, n_store);
        $display("test store and erase done");
    endtask
    task automatic t_edit;
        seq(26, 1, 12);
        chk("edit banner", 1'b0, banner);
        seq(26, 1, 15);
        chk("edit banner", 1'b1, banner);
        chk("scene led", 24'h004000, scene_led);
        seq(25, 1, 29);
        chk("edit banner", 1'b0, banner);
        $display("test edit done");
    endtask
    task automatic t_assign_erase;
        seq(25, 4, 1, 5, 6, 8);
        seq(25, 3, 6, 6, 6);
        chk("assign mode", 1'b1, assign_m);
        i_op.tap(1);
        chk("fader index", 5'h00, fader);
        seq(25, 1, 5);
        seq(25, 1, 24);
        chk("routing", 48'h800011, routing);
        i_op.tap(2);
        chk("fader index", 5'h01, fader);
        chk("routing", 48'h2, routing);
        i_op.tap(1);
        chk("routing", 48'h800011, routing);
        seq(25, 1, 29);
        chk("assign mode", 1'b0, assign_m);
        seq(25, 4, 1, 5, 6, 8);
        seq(25, 4, 1, 3, 2, 3);
        chk("erase all count", 1, n_all);
        chk("all leds", 1'b1, all_leds);
        chk("temp steps", 10'h0, steps);
        seq(25, 1, 29);
        chk("record led", 1'b0, rec_led);
        seq(25, 4, 1, 5, 6, 8);
        seq(25, 3, 6, 6, 6);
        i_op.tap(1);
        chk("routing", 48'h1, routing);
        $display("test assign and erase all done");
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        repeat (4) @(posedge i_clk);
        chk("page", 3'h1, page);
        chk("record led", 1'b0, rec_led);
        t_refused();
        t_arm();
        t_page_steps();
        t_store_erase();
        t_edit();
        t_assign_erase();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        err_total++;
        wrap_up();
    end
endmodule // panel_programming_sequencer_tb
bind pps_sequencer pps_sequencer_sva i_sva (.i_clk(i_clk), .i_rstn(i_rstn), .o_record_led(o_record_led),
    .o_all_leds(o_all_leds), .o_scene_led(o_scene_led), .o_edit_mode_banner(o_edit_mode_banner), .o_page(o_page),
    .o_step_pulse(o_step_pulse), .o_temp_steps(o_temp_steps), .o_store_pulse(o_store_pulse),
    .o_erase_pulse(o_erase_pulse), .o_scene_index(o_scene_index), .o_erase_all_pulse(o_erase_all_pulse));
